// [ddc_config_bank.sv]
// Datapath configuration register bank with sync, delay and alarm control
//
// Summary of operation
// - Datapath bit 7 enables quadrature offset correction
// - Datapath bit 6 enables phase and gain correction
// - Datapath bit 5 enables 2x interpolation stage
// - Bit 4 enables 4x stage; needs bit 5
// - Datapath bit 2 runs the pattern checker
// - Datapath bit 0 selects two's complement input
// - Sync bit 5 asserts sync until written zero
// - Sync bit 4 selects register sync, ignores strobe
// - Delay field delays converter data 0 to 3
// - Auto clear alarms after 64 good samples
// - Bits 4:2 load read pointer on sync
// - FIFO bit 1 enables two-apart pointer alarm
// - FIFO bit 0 enables one-apart pointer alarm
// - Channel A current scale is field plus one
// - Channel B current scale likewise from bits 3:0
// - Reset values 0x11, 0x00, 0x10, 0xff
// - Pattern mismatch raises the pattern alarm bit
`timescale 1ns/1ns
module ddc_config_bank #(
  parameter int SAMPLE_W = 16
) (
  input wire logic core_clk, // Converter clock
  input wire logic reset, // Async reset, active high
  input wire logic reg_wr_en, // Register write strobe
  input wire logic reg_rd_en, // Register read strobe
  input wire logic [ddc_pkg::ADDR_W-1:0] reg_addr, // Register offset
  input wire logic [ddc_pkg::DATA_W-1:0] reg_wdata, // Write data
  output logic [ddc_pkg::DATA_W-1:0] reg_rdata, // Read data, held
  output logic reg_rd_valid, // Read data valid pulse
  input wire logic frame_sync, // Normal input sync strobe
  input wire logic sample_valid, // Input sample present
  input wire logic [SAMPLE_W-1:0] sample_data, // Input sample
  input wire logic [SAMPLE_W-1:0] expected_pattern, // Checker pattern
  input wire logic near_two_event, // FIFO pointers two apart
  input wire logic near_one_event, // FIFO pointers one apart
  input wire logic [ddc_pkg::ALARM_W-1:0] alarm_clear, // Host alarm clear pulses
  input wire logic [SAMPLE_W-1:0] conv_data_in, // Data toward converters
  output logic [SAMPLE_W-1:0] conv_data_out, // Delayed converter data
  output logic qmc_offset_enable, // Offset correction on
  output logic qmc_correct_enable, // Phase and gain correction on
  output logic interp_stage_one_enable, // 2x stage active
  output logic interp_stage_two_enable, // 4x stage active
  output logic pattern_check_enable, // Pattern checker running
  output logic twos_complement_input, // Input format select
  output logic sync_level, // Selected sync level
  output logic read_ptr_load, // Read pointer load pulse
  output logic [ddc_pkg::OFFSET_W-1:0] read_ptr_start, // Read pointer load value
  output logic [ddc_pkg::SCALE_W:0] scale_a, // Channel A current multiple
  output logic [ddc_pkg::SCALE_W:0] scale_b, // Channel B current multiple
  output logic [ddc_pkg::ALARM_W-1:0] alarm_flags // Sticky alarms
);
  logic [7:0] datapath_control_reg;
  logic [7:0] datapath_control_next;
  logic [7:0] sync_and_delay_control_reg;
  logic [7:0] sync_and_delay_control_next;
  logic [7:0] fifo_alarm_control_reg;
  logic [7:0] fifo_alarm_control_next;
  logic [7:0] output_current_scale_reg;
  logic [7:0] output_current_scale_next;
  logic [7:0] rdata_next;
  logic rd_valid_next;
  logic sync_next;
  logic load_next;
  logic [ddc_pkg::SCALE_W:0] scale_a_next;
  logic [ddc_pkg::SCALE_W:0] scale_b_next;
  logic [5:0] ctl_next;

  // Merge a write into a register, leaving reserved bits at reset
  function automatic logic [7:0] merge_write(input logic [7:0] wdata,
                                             input logic [7:0] wmask, input logic [7:0] rst);
    merge_write = (wdata & wmask) | (rst & ~wmask);
  endfunction : merge_write

  // Write decode; an unmapped offset changes nothing
  always_comb begin
    datapath_control_next = datapath_control_reg;
    sync_and_delay_control_next = sync_and_delay_control_reg;
    fifo_alarm_control_next = fifo_alarm_control_reg;
    output_current_scale_next = output_current_scale_reg;
    if (reg_wr_en) begin
      unique case (reg_addr)
        ddc_pkg::OFS_DATAPATH: begin
          datapath_control_next = merge_write(reg_wdata,
                                              ddc_pkg::WMASK_DATAPATH, ddc_pkg::RST_DATAPATH);
        end
        ddc_pkg::OFS_SYNC_DELAY: begin
          sync_and_delay_control_next = merge_write(reg_wdata,
                                                    ddc_pkg::WMASK_SYNC_DELAY, ddc_pkg::RST_SYNC_DELAY);
        end
        ddc_pkg::OFS_FIFO_ALARM: begin
          fifo_alarm_control_next = merge_write(reg_wdata,
                                                ddc_pkg::WMASK_FIFO_ALARM, ddc_pkg::RST_FIFO_ALARM);
        end
        ddc_pkg::OFS_CURRENT: begin
          output_current_scale_next = merge_write(reg_wdata,
                                                  ddc_pkg::WMASK_CURRENT, ddc_pkg::RST_CURRENT);
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_valid_next = reg_rd_en;
    rdata_next = reg_rdata;
    if (reg_rd_en) begin
      unique case (reg_addr)
        ddc_pkg::OFS_DATAPATH: rdata_next = datapath_control_reg;
        ddc_pkg::OFS_SYNC_DELAY: rdata_next = sync_and_delay_control_reg;
        ddc_pkg::OFS_FIFO_ALARM: rdata_next = fifo_alarm_control_reg;
        ddc_pkg::OFS_CURRENT: rdata_next = output_current_scale_reg;
        default: rdata_next = '0;
      endcase
    end
  end

  // Register storage; reset values come from the map
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      datapath_control_reg <= ddc_pkg::RST_DATAPATH;
      sync_and_delay_control_reg <= ddc_pkg::RST_SYNC_DELAY;
      fifo_alarm_control_reg <= ddc_pkg::RST_FIFO_ALARM;
      output_current_scale_reg <= ddc_pkg::RST_CURRENT;
      reg_rdata <= '0;
      reg_rd_valid <= 1'b0;
    end else begin
      datapath_control_reg <= datapath_control_next;
      sync_and_delay_control_reg <= sync_and_delay_control_next;
      fifo_alarm_control_reg <= fifo_alarm_control_next;
      output_current_scale_reg <= output_current_scale_next;
      reg_rdata <= rdata_next;
      reg_rd_valid <= rd_valid_next;
    end
  end

  // Datapath controls decoded from the stored fields
  always_comb begin
    ctl_next[0] = datapath_control_reg[ddc_pkg::BIT_QMC_OFFSET];
    ctl_next[1] = datapath_control_reg[ddc_pkg::BIT_QMC_CORRECT];
    ctl_next[2] = datapath_control_reg[ddc_pkg::BIT_STAGE_ONE];
    // The 4x stage only runs behind the 2x stage, so a lone bit 4 is held off
    ctl_next[3] = datapath_control_reg[ddc_pkg::BIT_STAGE_TWO]
                  & datapath_control_reg[ddc_pkg::BIT_STAGE_ONE];
    ctl_next[4] = datapath_control_reg[ddc_pkg::BIT_PATTERN_CHK];
    ctl_next[5] = datapath_control_reg[ddc_pkg::BIT_TWOS];
  end

  // Sync source selection; the register bit stands until the host clears it
  always_comb begin
    if (sync_and_delay_control_reg[ddc_pkg::BIT_REG_SYNC_ENA]) begin
      sync_next = sync_and_delay_control_reg[ddc_pkg::BIT_REG_SYNC];
    end else begin
      sync_next = frame_sync;
    end
    // Pointer is loaded once per sync, on its rising edge
    load_next = sync_next && !sync_level;
  end

  // Current scaling multiples, field value plus one
  always_comb begin
    scale_a_next = {1'b0, output_current_scale_reg[ddc_pkg::SCALE_A_LSB +: ddc_pkg::SCALE_W]} + 1'b1;
    scale_b_next = {1'b0, output_current_scale_reg[ddc_pkg::SCALE_B_LSB +: ddc_pkg::SCALE_W]} + 1'b1;
  end

  // Control outputs, all registered
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      qmc_offset_enable <= 1'b0;
      qmc_correct_enable <= 1'b0;
      interp_stage_one_enable <= 1'b0;
      interp_stage_two_enable <= 1'b0;
      pattern_check_enable <= 1'b0;
      twos_complement_input <= 1'b0;
      sync_level <= 1'b0;
      read_ptr_load <= 1'b0;
      read_ptr_start <= '0;
      scale_a <= '0;
      scale_b <= '0;
    end else begin
      qmc_offset_enable <= ctl_next[0];
      qmc_correct_enable <= ctl_next[1];
      interp_stage_one_enable <= ctl_next[2];
      interp_stage_two_enable <= ctl_next[3];
      pattern_check_enable <= ctl_next[4];
      twos_complement_input <= ctl_next[5];
      sync_level <= sync_next;
      read_ptr_load <= load_next;
      read_ptr_start <= fifo_alarm_control_reg[ddc_pkg::OFFSET_LSB +: ddc_pkg::OFFSET_W];
      scale_a <= scale_a_next;
      scale_b <= scale_b_next;
    end
  end

  // Converter data delay, selected by the delay field
  ddc_delay_line #(
    .WIDTH(SAMPLE_W),
    .MAX_DELAY(ddc_pkg::MAX_OUT_DELAY)
  ) u_delay (
    .core_clk(core_clk),
    .reset(reset),
    .data_in(conv_data_in),
    .delay_sel(sync_and_delay_control_reg[ddc_pkg::DELAY_LSB +: ddc_pkg::DELAY_W]),
    .data_out(conv_data_out)
  );

  // Alarm flags; checker follows the stored enable directly
  ddc_alarm_tracker #(
    .WIDTH(SAMPLE_W),
    .GOOD_RUN(ddc_pkg::GOOD_RUN)
  ) u_alarm (
    .core_clk(core_clk),
    .reset(reset),
    .sample_valid(sample_valid),
    .sample_data(sample_data),
    .expected_pattern(expected_pattern),
    .pattern_check_enable(datapath_control_reg[ddc_pkg::BIT_PATTERN_CHK]),
    .near_two_event(near_two_event),
    .near_one_event(near_one_event),
    .near_two_enable(fifo_alarm_control_reg[ddc_pkg::BIT_NEAR_TWO]),
    .near_one_enable(fifo_alarm_control_reg[ddc_pkg::BIT_NEAR_ONE]),
    .auto_clear_enable(fifo_alarm_control_reg[ddc_pkg::BIT_AUTO_CLEAR]),
    .alarm_clear(alarm_clear),
    .alarm_flags(alarm_flags)
  );
endmodule : ddc_config_bank

// [ddc_pkg.sv]
// Package with register map, field positions and reset values of the datapath config bank
package ddc_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [4:0] OFS_DATAPATH = 5'h01;
  localparam logic [4:0] OFS_SYNC_DELAY = 5'h02;
  localparam logic [4:0] OFS_FIFO_ALARM = 5'h03;
  localparam logic [4:0] OFS_CURRENT = 5'h04;
  // Reset values
  localparam logic [7:0] RST_DATAPATH = 8'h11;
  localparam logic [7:0] RST_SYNC_DELAY = 8'h00;
  localparam logic [7:0] RST_FIFO_ALARM = 8'h10;
  localparam logic [7:0] RST_CURRENT = 8'hff;
  // Writable bits; reserved bits hold their reset value
  localparam logic [7:0] WMASK_DATAPATH = 8'hf5;
  localparam logic [7:0] WMASK_SYNC_DELAY = 8'h33;
  localparam logic [7:0] WMASK_FIFO_ALARM = 8'h9f;
  localparam logic [7:0] WMASK_CURRENT = 8'hff;
  // Datapath control fields
  localparam int BIT_QMC_OFFSET = 7;
  localparam int BIT_QMC_CORRECT = 6;
  localparam int BIT_STAGE_ONE = 5;
  localparam int BIT_STAGE_TWO = 4;
  localparam int BIT_PATTERN_CHK = 2;
  localparam int BIT_TWOS = 0;
  // Sync and delay fields
  localparam int BIT_REG_SYNC = 5;
  localparam int BIT_REG_SYNC_ENA = 4;
  localparam int DELAY_LSB = 0;
  localparam int DELAY_W = 2;
  // FIFO alarm control fields
  localparam int BIT_AUTO_CLEAR = 7;
  localparam int OFFSET_LSB = 2;
  localparam int OFFSET_W = 3;
  localparam int BIT_NEAR_TWO = 1;
  localparam int BIT_NEAR_ONE = 0;
  // Current scale fields
  localparam int SCALE_A_LSB = 4;
  localparam int SCALE_B_LSB = 0;
  localparam int SCALE_W = 4;
  // Alarm vector positions
  localparam int ALARM_W = 3;
  localparam int ALM_PATTERN = 2;
  localparam int ALM_NEAR_TWO = 1;
  localparam int ALM_NEAR_ONE = 0;
  // Good samples needed before automatic alarm clearing
  localparam int GOOD_RUN = 64;
  localparam int MAX_OUT_DELAY = 3;
endpackage : ddc_pkg

// [ddc_delay_line.sv]
// Selectable output delay line for converter data
`timescale 1ns/1ns
module ddc_delay_line #(
  parameter int WIDTH = 16,
  parameter int MAX_DELAY = ddc_pkg::MAX_OUT_DELAY
) (
  input wire logic core_clk, // Converter clock
  input wire logic reset, // Async reset, active high
  input wire logic [WIDTH-1:0] data_in, // Samples in
  input wire logic [ddc_pkg::DELAY_W-1:0] delay_sel, // Extra cycles of delay
  output logic [WIDTH-1:0] data_out // Delayed samples
);
  logic [WIDTH-1:0] tap_reg [0:MAX_DELAY];
  logic [WIDTH-1:0] tap_next [0:MAX_DELAY];
  logic [WIDTH-1:0] out_next;

  // Tap zero is the input, each later tap one cycle older
  always_comb begin
    tap_next[0] = data_in;
    for (int i = 1; i <= MAX_DELAY; i++) begin
      tap_next[i] = tap_reg[i-1];
    end
    out_next = tap_next[delay_sel];
  end

  // Output flop adds one fixed cycle to every setting
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i <= MAX_DELAY; i++) begin
        tap_reg[i] <= '0;
      end
      data_out <= '0;
    end else begin
      for (int i = 0; i <= MAX_DELAY; i++) begin
        tap_reg[i] <= tap_next[i];
      end
      data_out <= out_next;
    end
  end
endmodule : ddc_delay_line

// [ddc_alarm_tracker.sv]
// Sticky alarm flags with pattern check and automatic clearing after a good run
`timescale 1ns/1ns
module ddc_alarm_tracker #(
  parameter int WIDTH = 16,
  parameter int GOOD_RUN = ddc_pkg::GOOD_RUN
) (
  input wire logic core_clk, // Converter clock
  input wire logic reset, // Async reset, active high
  input wire logic sample_valid, // Input sample present
  input wire logic [WIDTH-1:0] sample_data, // Received sample
  input wire logic [WIDTH-1:0] expected_pattern, // Programmed pattern
  input wire logic pattern_check_enable, // Checker running
  input wire logic near_two_event, // Pointers two apart
  input wire logic near_one_event, // Pointers one apart
  input wire logic near_two_enable, // Gate for two-apart alarm
  input wire logic near_one_enable, // Gate for one-apart alarm
  input wire logic auto_clear_enable, // Clear after good run
  input wire logic [ddc_pkg::ALARM_W-1:0] alarm_clear, // Host clear pulses
  output logic [ddc_pkg::ALARM_W-1:0] alarm_flags // Sticky alarms
);
  localparam int CNT_W = $clog2(GOOD_RUN + 1);
  logic [CNT_W-1:0] good_cnt_reg;
  logic [CNT_W-1:0] good_cnt_next;
  logic [ddc_pkg::ALARM_W-1:0] alarm_next;
  logic [ddc_pkg::ALARM_W-1:0] raise;
  logic mismatch;
  logic run_done;

  // Events are applied after clears so a same-cycle event is never lost
  always_comb begin
    mismatch = pattern_check_enable && sample_valid && (sample_data != expected_pattern);
    raise = '0;
    raise[ddc_pkg::ALM_PATTERN] = mismatch;
    raise[ddc_pkg::ALM_NEAR_TWO] = near_two_enable && near_two_event;
    raise[ddc_pkg::ALM_NEAR_ONE] = near_one_enable && near_one_event;
    good_cnt_next = good_cnt_reg;
    run_done = 1'b0;
    if (|raise) begin
      good_cnt_next = '0;
    end else if (sample_valid) begin
      if (good_cnt_reg == CNT_W'(GOOD_RUN - 1)) begin
        run_done = auto_clear_enable;
        good_cnt_next = '0;
      end else begin
        good_cnt_next = good_cnt_reg + 1'b1;
      end
    end
    alarm_next = alarm_flags & ~alarm_clear;
    if (run_done) begin
      alarm_next = '0;
    end
    alarm_next = alarm_next | raise;
  end

  // State registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      good_cnt_reg <= '0;
      alarm_flags <= '0;
    end else begin
      good_cnt_reg <= good_cnt_next;
      alarm_flags <= alarm_next;
    end
  end
endmodule : ddc_alarm_tracker

// [ddc_config_bank_sva.sv]
// Port-level checker of the datapath configuration register bank
`timescale 1ns/1ns
module ddc_config_bank_sva #(
  parameter int SAMPLE_W = 16
) (
  input wire logic core_clk, // Converter clock
  input wire logic reset, // Async reset, active high
  input wire logic reg_wr_en, // Write strobe
  input wire logic reg_rd_en, // Read strobe
  input wire logic [ddc_pkg::ADDR_W-1:0] reg_addr, // Offset
  input wire logic [ddc_pkg::DATA_W-1:0] reg_wdata, // Write data
  input wire logic [ddc_pkg::DATA_W-1:0] reg_rdata, // Read data
  input wire logic reg_rd_valid, // Read answer
  input wire logic sample_valid, // Sample present
  input wire logic [SAMPLE_W-1:0] sample_data, // Sample
  input wire logic [SAMPLE_W-1:0] expected_pattern, // Checker pattern
  input wire logic qmc_offset_enable, // Offset correction
  input wire logic qmc_correct_enable, // Phase and gain correction
  input wire logic interp_stage_one_enable, // 2x stage
  input wire logic interp_stage_two_enable, // 4x stage
  input wire logic pattern_check_enable, // Checker running
  input wire logic twos_complement_input, // Input format
  input wire logic sync_level, // Selected sync
  input wire logic read_ptr_load, // Pointer load pulse
  input wire logic [ddc_pkg::OFFSET_W-1:0] read_ptr_start, // Pointer load value
  input wire logic [ddc_pkg::SCALE_W:0] scale_a, // Channel A multiple
  input wire logic [ddc_pkg::SCALE_W:0] scale_b, // Channel B multiple
  input wire logic [ddc_pkg::ALARM_W-1:0] alarm_flags // Sticky alarms
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // Bus answers and held read data
  rd_answer_a: assert property (reg_rd_valid == $past(reg_rd_en))
    else $error("read answer not one cycle after strobe");
  rdata_hold_a: assert property (!reg_rd_valid |-> $stable(reg_rdata))
    else $error("read data moved without an answer");
  // Control copies two edges after a write; bit 4 is checked through the stage pairing
  datapath_copy_a: assert property (reg_wr_en && reg_addr == ddc_pkg::OFS_DATAPATH |-> ##2
    ({qmc_offset_enable, qmc_correct_enable, interp_stage_one_enable, 2'b00, pattern_check_enable, 1'b0,
    twos_complement_input} == ($past(reg_wdata, 2) & 8'he5))) else $error("datapath controls do not follow write");
  stage_pair_a: assert property (interp_stage_two_enable |-> interp_stage_one_enable)
    else $error("4x stage active without 2x stage");
  scale_copy_a: assert property (reg_wr_en && reg_addr == ddc_pkg::OFS_CURRENT |-> ##2
    (scale_a == {1'b0, $past(reg_wdata[7:4], 2)} + 5'h01 && scale_b == {1'b0, $past(reg_wdata[3:0], 2)} + 5'h01))
    else $error("current scale does not follow write");
  ptr_start_a: assert property (reg_wr_en && reg_addr == ddc_pkg::OFS_FIFO_ALARM |-> ##2
    ({read_ptr_start, 2'b00} == ($past(reg_wdata, 2) & 8'h1c))) else $error("pointer start does not follow write");
  ptr_load_a: assert property (read_ptr_load == $rose(sync_level))
    else $error("pointer load not on sync rise");
  // Mismatch sampled while the checker bit is set raises the alarm on the next edge
  pattern_alarm_a: assert property (sample_valid && sample_data != expected_pattern ##1 pattern_check_enable
    |-> alarm_flags[ddc_pkg::ALM_PATTERN]) else $error("pattern mismatch without alarm");
  reset_view_a: assert property ($fell(reset) |=> scale_a == 5'h10 && scale_b == 5'h10 && read_ptr_start == 3'h4
    && twos_complement_input && !interp_stage_two_enable && alarm_flags == 3'h0) else $error("bad view after reset");
  cover property (interp_stage_two_enable);
  cover property (read_ptr_load);
  cover property ($fell(alarm_flags[ddc_pkg::ALM_PATTERN]));
endmodule : ddc_config_bank_sva

bind ddc_config_bank ddc_config_bank_sva #(.SAMPLE_W(SAMPLE_W)) ddc_config_bank_sva_inst (
  .core_clk(core_clk), .reset(reset), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .sample_valid(sample_valid),
  .sample_data(sample_data), .expected_pattern(expected_pattern), .qmc_offset_enable(qmc_offset_enable),
  .qmc_correct_enable(qmc_correct_enable), .interp_stage_one_enable(interp_stage_one_enable),
  .interp_stage_two_enable(interp_stage_two_enable), .pattern_check_enable(pattern_check_enable),
  .twos_complement_input(twos_complement_input), .sync_level(sync_level), .read_ptr_load(read_ptr_load),
  .read_ptr_start(read_ptr_start), .scale_a(scale_a), .scale_b(scale_b), .alarm_flags(alarm_flags));

// [ddc_host_model.sv]
// Host controller model issuing single-byte register writes and reads
`timescale 1ns/1ns
module ddc_host_model (
  input wire logic core_clk, // Converter clock
  output logic reg_wr_en, // Write strobe
  output logic reg_rd_en, // Read strobe
  output logic [ddc_pkg::ADDR_W-1:0] reg_addr, // Offset
  output logic [ddc_pkg::DATA_W-1:0] reg_wdata // Write data
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 5'h1f;
    reg_wdata = 8'h00;
  end
  // Released lines show the inverse so stale values cannot pass for live ones
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk) begin
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
    end
    @(posedge core_clk) begin
      reg_wr_en <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
    end
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge core_clk) begin
      reg_rd_en <= 1'b1;
      reg_addr <= a;
    end
    @(posedge core_clk) begin
      reg_rd_en <= 1'b0;
      reg_addr <= ~a;
    end
  endtask : rd
endmodule : ddc_host_model

// [tb_ddc_config_bank.sv]
// Self-checking testbench of the datapath configuration register bank
`timescale 1ns/1ns
module tb_ddc_config_bank;
  logic core_clk, reset, frame_sync, sample_valid, near_two_event, near_one_event, reg_wr_en, reg_rd_en;
  logic reg_rd_valid, read_ptr_load, sync_level, qmc_offset_enable, qmc_correct_enable, twos_complement_input;
  logic interp_stage_one_enable, interp_stage_two_enable, pattern_check_enable;
  logic [4:0] reg_addr, scale_a, scale_b;
  logic [7:0] reg_wdata, reg_rdata, d1, d3, d4;
  logic [2:0] alarm_clear, alarm_flags, read_ptr_start;
  logic [15:0] sample_data, expected_pattern, conv_data_in, conv_data_out, pat;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  ddc_host_model ddc_host_model_inst (.core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  ddc_config_bank #(.SAMPLE_W(16)) ddc_config_bank_inst (.core_clk(core_clk), .reset(reset),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .frame_sync(frame_sync), .sample_valid(sample_valid),
    .sample_data(sample_data), .expected_pattern(expected_pattern), .near_two_event(near_two_event),
    .near_one_event(near_one_event), .alarm_clear(alarm_clear), .conv_data_in(conv_data_in),
    .conv_data_out(conv_data_out), .qmc_offset_enable(qmc_offset_enable), .qmc_correct_enable(qmc_correct_enable),
    .interp_stage_one_enable(interp_stage_one_enable), .interp_stage_two_enable(interp_stage_two_enable),
    .pattern_check_enable(pattern_check_enable), .twos_complement_input(twos_complement_input),
    .sync_level(sync_level), .read_ptr_load(read_ptr_load), .read_ptr_start(read_ptr_start),
    .scale_a(scale_a), .scale_b(scale_b), .alarm_flags(alarm_flags));
  // 20 MHz converter clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // Note the expected byte before the read goes out
  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    ddc_host_model_inst.rd(a);
  endtask : rdchk
  // Derived outputs land one edge after the register
  task automatic settle;
    @(posedge core_clk);
    #1;
  endtask : settle
  task automatic send(input logic [15:0] d, input int n);
    repeat (n) @(posedge core_clk) begin
      sample_valid <= 1'b1;
      sample_data <= d;
    end
    @(posedge core_clk) sample_valid <= 1'b0;
    #1;
  endtask : send
  task automatic pulse(input logic [1:0] ev, input logic [2:0] clr);
    @(posedge core_clk) begin
      {near_two_event, near_one_event} <= ev;
      alarm_clear <= clr;
    end
    @(posedge core_clk) begin
      {near_two_event, near_one_event} <= 2'b00;
      alarm_clear <= 3'h0;
    end
    #1;
  endtask : pulse
  // Read answers are matched with the oldest note; negedge keeps clear of the launch edge
  always @(negedge core_clk) begin
    if (reg_rd_valid === 1'b1) check(reg_rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
  end
  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #1_000_000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    {reset, frame_sync, sample_valid, near_two_event, near_one_event, alarm_clear} = 8'h80;
    {sample_data, expected_pattern, conv_data_in} = 48'h0;
    void'($urandom(12));
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    // Reset values, unmapped offsets ignored and read as zero
    rdchk(5'h01, 8'h11);
    rdchk(5'h02, 8'h00);
    rdchk(5'h03, 8'h10);
    rdchk(5'h04, 8'hff);
    ddc_host_model_inst.wr(5'h05, 8'hff);
    rdchk(5'h05, 8'h00);
    rdchk(5'h00, 8'h00);
    // Random legal contents; reserved bits written as zero by the host
    for (int i = 0; i < 6; i++) begin
      d1 = 8'($urandom()) & ddc_pkg::WMASK_DATAPATH;
      if (d1[4]) d1[5] = 1'b1;
      d3 = 8'($urandom()) & ddc_pkg::WMASK_FIFO_ALARM;
      d4 = 8'($urandom());
      ddc_host_model_inst.wr(ddc_pkg::OFS_DATAPATH, d1);
      ddc_host_model_inst.wr(ddc_pkg::OFS_FIFO_ALARM, d3);
      ddc_host_model_inst.wr(ddc_pkg::OFS_CURRENT, d4);
      settle();
      check({qmc_offset_enable, qmc_correct_enable}, d1[7:6]);
      check({interp_stage_one_enable, interp_stage_two_enable}, d1[5:4]);
      check({pattern_check_enable, twos_complement_input}, {d1[2], d1[0]});
      check(read_ptr_start, d3[4:2]);
      check(scale_a, {1'b0, d4[7:4]} + 5'h01);
      check(scale_b, {1'b0, d4[3:0]} + 5'h01);
      rdchk(ddc_pkg::OFS_DATAPATH, d1);
      rdchk(ddc_pkg::OFS_FIFO_ALARM, d3);
      rdchk(ddc_pkg::OFS_CURRENT, d4);
    end
    // Strobe sync, then register sync overriding a strobe held high
    @(posedge core_clk) frame_sync <= 1'b1;
    settle();
    check({sync_level, read_ptr_load}, 2'b11);
    settle();
    check(read_ptr_load, 1'b0);
    ddc_host_model_inst.wr(ddc_pkg::OFS_SYNC_DELAY, 8'h10);
    settle();
    check(sync_level, 1'b0);
    ddc_host_model_inst.wr(ddc_pkg::OFS_SYNC_DELAY, 8'h30);
    settle();
    check({sync_level, read_ptr_load}, 2'b11);
    ddc_host_model_inst.wr(ddc_pkg::OFS_SYNC_DELAY, 8'h10);
    settle();
    check(sync_level, 1'b0);
    @(posedge core_clk) frame_sync <= 1'b0;
    // Each output delay: marker appears after delay plus the fixed cycle, then leaves
    for (int d = 0; d < 4; d++) begin
      ddc_host_model_inst.wr(ddc_pkg::OFS_SYNC_DELAY, 8'(d));
      settle();
      pat = 16'($urandom());
      @(posedge core_clk) conv_data_in <= pat;
      @(posedge core_clk) conv_data_in <= ~pat;
      repeat (d) @(posedge core_clk);
      #1 check(conv_data_out, pat);
      settle();
      check(conv_data_out, ~pat);
    end
    // Proximity alarms gated by their enables, host clear
    @(posedge core_clk) expected_pattern <= pat;
    ddc_host_model_inst.wr(ddc_pkg::OFS_FIFO_ALARM, 8'h10);
    ddc_host_model_inst.wr(ddc_pkg::OFS_DATAPATH, 8'h11);
    settle();
    pulse(2'b11, 3'h0);
    check(alarm_flags, 3'h0);
    ddc_host_model_inst.wr(ddc_pkg::OFS_FIFO_ALARM, 8'h13);
    settle();
    pulse(2'b01, 3'h0);
    check(alarm_flags, 3'h1);
    pulse(2'b10, 3'h0);
    check(alarm_flags, 3'h3);
    pulse(2'b00, 3'h3);
    check(alarm_flags, 3'h0);
    // Pattern checker off then on; good run clears only with auto clear enabled
    send(~pat, 1);
    check(alarm_flags, 3'h0);
    ddc_host_model_inst.wr(ddc_pkg::OFS_DATAPATH, 8'h35);
    settle();
    send(~pat, 1);
    check(alarm_flags, 3'h4);
    send(pat, 64);
    check(alarm_flags, 3'h4);
    ddc_host_model_inst.wr(ddc_pkg::OFS_FIFO_ALARM, 8'h93);
    settle();
    pulse(2'b01, 3'h0);
    send(~pat, 1);
    check(alarm_flags, 3'h5);
    send(pat, 63);
    check(alarm_flags, 3'h5);
    send(pat, 1);
    check(alarm_flags, 3'h0);
    // Second reset in mid-run restores the defaults
    @(posedge core_clk) reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rdchk(5'h01, 8'h11);
    rdchk(5'h03, 8'h10);
    repeat (3) @(posedge core_clk);
    print_verdict();
  end
endmodule : tb_ddc_config_bank
